// ---- design/cmp_pkg.sv ----
// Package: modes, thresholds and data carriers for the dual hysteresis comparator
package cmp_pkg;

  localparam int VAL_W    = 24;             // Signed actual value / reference width
  localparam int PCT_W    = 16;             // Signed percentage, 0.01 % per LSB
  localparam int MODE_W   = 8;
  localparam int NUM_CMP  = 2;
  localparam int NUM_SRC  = 12;
  localparam int PROD_W   = VAL_W + PCT_W;

  // Percentages in hundredths of a percent
  localparam logic signed [PCT_W-1:0] PCT_FULL    = 16'sh2710;   // 100.00 %
  localparam logic signed [PCT_W-1:0] PCT_MAX     = 16'sh7530;   // 300.00 %
  localparam logic signed [PCT_W-1:0] PCT_MIN     = -16'sh7530;  // -300.00 %
  localparam logic signed [PCT_W-1:0] ON_DEFAULT  = 16'sh2710;   // 100.00 %
  localparam logic signed [PCT_W-1:0] OFF_DEFAULT = 16'sh1388;   // 50.00 %

  // Fixed references, in the units of the matching quantity inputs
  localparam int TEMP_REF_DEGC  = 100;
  localparam int DCLINK_REF_V   = 1000;
  localparam logic signed [VAL_W-1:0] TEMP_REF   = VAL_W'(TEMP_REF_DEGC);
  localparam logic signed [VAL_W-1:0] DCLINK_REF = VAL_W'(DCLINK_REF_V);
  localparam logic signed [VAL_W-1:0] ANALOG_FULL_REF = 24'sh002710; // 100.00 %

  // Operating modes; the signed variants are base plus SIGNED_OFS
  localparam logic [MODE_W-1:0] MODE_OFF        = 8'h00;
  localparam logic [MODE_W-1:0] MODE_RMS_CUR    = 8'h01;
  localparam logic [MODE_W-1:0] MODE_ACT_CUR    = 8'h02;
  localparam logic [MODE_W-1:0] MODE_STATOR_F   = 8'h03;
  localparam logic [MODE_W-1:0] MODE_ENC_SPEED  = 8'h04;
  localparam logic [MODE_W-1:0] MODE_REP_F      = 8'h05;
  localparam logic [MODE_W-1:0] MODE_WIND_TEMP  = 8'h06;
  localparam logic [MODE_W-1:0] MODE_OUT_F      = 8'h07;
  localparam logic [MODE_W-1:0] MODE_DCLINK     = 8'h09;
  localparam logic [MODE_W-1:0] MODE_TORQUE_CUR = 8'h0A;
  localparam logic [MODE_W-1:0] MODE_FILT_CUR   = 8'h0B;
  localparam logic [MODE_W-1:0] MODE_INT_REF_F  = 8'h0C;
  localparam logic [MODE_W-1:0] MODE_REF_PCT    = 8'h0D;
  localparam logic [MODE_W-1:0] MODE_ACT_PCT    = 8'h0E;
  localparam logic [MODE_W-1:0] MODE_ANALOG     = 8'h0F;
  localparam logic [MODE_W-1:0] SIGNED_OFS      = 8'h64;   // 100
  localparam logic [MODE_W-1:0] SIGNED_LAST_LO  = 8'h6B;   // 107
  localparam logic [MODE_W-1:0] SIGNED_HI_A     = 8'h6F;   // 111
  localparam logic [MODE_W-1:0] SIGNED_HI_B     = 8'h70;   // 112

  // Live actual quantities, all signed, same control tick as the block
  typedef struct packed {
    logic signed [VAL_W-1:0] rms_current;
    logic signed [VAL_W-1:0] active_current;
    logic signed [VAL_W-1:0] stator_freq;
    logic signed [VAL_W-1:0] encoder1_speed;
    logic signed [VAL_W-1:0] repetition_freq;
    logic signed [VAL_W-1:0] winding_temp;
    logic signed [VAL_W-1:0] output_freq;
    logic signed [VAL_W-1:0] dclink_voltage;
    logic signed [VAL_W-1:0] torque_current;
    logic signed [VAL_W-1:0] filt_active_current;
    logic signed [VAL_W-1:0] int_ref_freq;
    logic signed [VAL_W-1:0] ref_percentage;
    logic signed [VAL_W-1:0] act_percentage;
    logic signed [VAL_W-1:0] first_multifunction_analog_input;
  } actual_values_t;

  // Reference quantities supplied by the drive configuration
  typedef struct packed {
    logic signed [VAL_W-1:0] rated_current;
    logic signed [VAL_W-1:0] max_frequency;
    logic signed [VAL_W-1:0] max_speed;
    logic signed [VAL_W-1:0] max_ref_percentage;
  } references_t;

  // Per-comparator settings
  typedef struct packed {
    logic        [MODE_W-1:0] mode;
    logic signed [PCT_W-1:0]  on_above;
    logic signed [PCT_W-1:0]  off_below;
  } cmp_cfg_t;

  // Per-comparator result pair
  typedef struct packed {
    logic result;
    logic result_n;
  } cmp_flags_t;

endpackage : cmp_pkg

// ---- design/dual_hysteresis_comparator.sv ----
// Two hysteresis comparators on selectable drive quantities
//
// Contract
// R1 - Two independent comparators, each with own mode and two percentage thresholds.
// R2 - Mode zero disables the comparator and holds its result inactive.
// R3 - Mode 1 compares RMS motor current against rated current.
// R4 - Mode 2 compares active current magnitude against rated current.
// R5 - Mode 3 compares stator frequency magnitude against maximum frequency.
// R6 - Mode 4 compares encoder 1 speed magnitude against derived maximum speed.
// R7 - Mode 5 compares repetition frequency magnitude against maximum frequency.
// R8 - Mode 6 compares winding temperature against fixed 100 degrees Celsius.
// R9 - Mode 7 compares actual output frequency magnitude against maximum frequency.
// R10 - Mode 9 compares DC-link voltage against fixed 1000 volts.
// R11 - Mode 10 uses torque current, mode 11 filtered active current, versus rated.
// R12 - Mode 12 compares internal reference frequency against maximum frequency.
// R13 - Modes 13 and 14 compare percentage values against maximum reference percentage.
// R14 - Mode 15 compares first analog input magnitude against 100 percent.
// R15 - Modes 100-107, 111, 112 compare signed values instead of magnitudes.
// R16 - Switch-on threshold spans -300 to +300 percent, default 100 percent.
// R17 - Switch-off threshold spans -300 to +300 percent, default 50 percent.
// R18 - Output turns on when quantity exceeds switch-on percentage of reference.
// R19 - Output turns off when quantity drops below switch-off percentage of reference; if it also exceeds switch-on, the output turns on.
// R20 - Each comparator gives a result flag, for internal use and digital output.
// R21 - Each comparator also gives the complement of its result flag.
// R22 - Between thresholds the output holds; after reset it is inactive.
// R23 - Unsigned modes take the absolute value before comparing.
`timescale 1ns/1ps
`default_nettype none

module dual_hysteresis_comparator
  import cmp_pkg::*;
(
  input  wire logic           core_clk_i,
  input  wire logic           rst_i,
  input  wire actual_values_t actual_i,
  input  wire references_t    refs_i,
  input  wire cmp_cfg_t       first_comparator_cfg_i,
  input  wire cmp_cfg_t       second_comparator_cfg_i,
  output var  cmp_flags_t     first_comparator_o,
  output var  cmp_flags_t     second_comparator_o,
  output var  logic [1:0]     cfg_clamped_o
);

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    cmp_flags_t [NUM_CMP-1:0] flags;
    logic       [NUM_CMP-1:0] clamped;
  } state_t;

  state_t state_r;
  state_t state_nxt;

  // ==========================================================================
  // Helpers
  // ==========================================================================
  // Out-of-range settings are clamped rather than rejected, so a bad write
  // still gives a usable comparison; the clamp is reported on a status bit.
  function automatic logic signed [PCT_W-1:0] clamp_pct(input logic signed [PCT_W-1:0] p);
    if (p > PCT_MAX) begin // R16 R17
      return PCT_MAX;
    end else if (p < PCT_MIN) begin
      return PCT_MIN;
    end else begin
      return p;
    end
  endfunction

  function automatic logic out_of_range(input logic signed [PCT_W-1:0] p);
    return (p > PCT_MAX) || (p < PCT_MIN);
  endfunction

  // One bit wider, so the most negative value has a positive twin
  function automatic logic signed [VAL_W:0] magnitude(input logic signed [VAL_W-1:0] v);
    logic signed [VAL_W:0] w;
    w = (VAL_W+1)'(v);
    return w[VAL_W] ? -w : w; // R23
  endfunction

  // Reference times clamped percentage, shared by both limits
  function automatic logic signed [PROD_W-1:0] scale_limit(
    input logic signed [VAL_W-1:0] ref_v,
    input logic signed [PCT_W-1:0] pct
  );
    return PROD_W'(ref_v) * PROD_W'(clamp_pct(pct)); // R16 R17
  endfunction

  // Signed-mode test; only 100-107, 111 and 112 are signed
  function automatic logic is_signed_mode(input logic [MODE_W-1:0] m);
    return ((m >= SIGNED_OFS) && (m <= SIGNED_LAST_LO))
        || (m == SIGNED_HI_A) || (m == SIGNED_HI_B); // R15
  endfunction

  // Selected quantity, reference and validity for one base mode
  typedef struct packed {
    logic                    valid;
    logic signed [VAL_W-1:0] value;
    logic signed [VAL_W-1:0] ref_val;
  } sel_t;

  function automatic sel_t select_src(input logic [MODE_W-1:0] m,
                                      input actual_values_t    a,
                                      input references_t       r);
    sel_t s;
    s.valid   = 1'b1;
    s.value   = '0;
    s.ref_val = '0;
    case (m)
      MODE_RMS_CUR: begin // R3
        s.value   = a.rms_current;
        s.ref_val = r.rated_current;
      end
      MODE_ACT_CUR: begin // R4
        s.value   = a.active_current;
        s.ref_val = r.rated_current;
      end
      MODE_STATOR_F: begin // R5
        s.value   = a.stator_freq;
        s.ref_val = r.max_frequency;
      end
      MODE_ENC_SPEED: begin // R6
        s.value   = a.encoder1_speed;
        s.ref_val = r.max_speed;
      end
      MODE_REP_F: begin // R7
        s.value   = a.repetition_freq;
        s.ref_val = r.max_frequency;
      end
      MODE_WIND_TEMP: begin // R8
        s.value   = a.winding_temp;
        s.ref_val = TEMP_REF;
      end
      MODE_OUT_F: begin // R9
        s.value   = a.output_freq;
        s.ref_val = r.max_frequency;
      end
      MODE_DCLINK: begin // R10
        s.value   = a.dclink_voltage;
        s.ref_val = DCLINK_REF;
      end
      MODE_TORQUE_CUR: begin // R11
        s.value   = a.torque_current;
        s.ref_val = r.rated_current;
      end
      MODE_FILT_CUR: begin // R11
        s.value   = a.filt_active_current;
        s.ref_val = r.rated_current;
      end
      MODE_INT_REF_F: begin // R12
        s.value   = a.int_ref_freq;
        s.ref_val = r.max_frequency;
      end
      MODE_REF_PCT: begin // R13
        s.value   = a.ref_percentage;
        s.ref_val = r.max_ref_percentage;
      end
      MODE_ACT_PCT: begin // R13
        s.value   = a.act_percentage;
        s.ref_val = r.max_ref_percentage;
      end
      MODE_ANALOG: begin // R14
        s.value   = a.first_multifunction_analog_input;
        s.ref_val = ANALOG_FULL_REF;
      end
      default: begin
        // Off, mode 8 and anything unknown disable the comparator
        s.valid = 1'b0; // R2
      end
    endcase
    return s;
  endfunction

  // One comparator step: returns the next result level
  // Value is scaled by 100.00 % and the reference by the threshold, so no
  // division is needed; the product width holds the worst case exactly.
  function automatic logic cmp_step(input cmp_cfg_t       c,
                                    input actual_values_t a,
                                    input references_t    r,
                                    input logic           prev);
    logic                     signed_mode;
    logic [MODE_W-1:0]        base;
    sel_t                     s;
    logic signed [VAL_W:0]    v;
    logic signed [PROD_W-1:0] v_scaled;
    logic signed [PROD_W-1:0] on_lim;
    logic signed [PROD_W-1:0] off_lim;
    logic                     nxt;
    signed_mode = is_signed_mode(c.mode);
    base        = signed_mode ? MODE_W'(c.mode - SIGNED_OFS) : c.mode; // R15
    s           = select_src(base, a, r);
    v           = signed_mode ? (VAL_W+1)'(s.value) : magnitude(s.value); // R15 R23
    v_scaled    = PROD_W'(v) * PROD_W'(PCT_FULL);
    on_lim      = scale_limit(s.ref_val, c.on_above);
    off_lim     = scale_limit(s.ref_val, c.off_below);
    nxt         = prev; // R22
    if (!s.valid || (c.mode == MODE_OFF)) begin
      nxt = 1'b0; // R2
    end else if (v_scaled > on_lim) begin
      nxt = 1'b1; // R18
    end else if (v_scaled < off_lim) begin
      nxt = 1'b0; // R19
    end
    return nxt;
  endfunction

  // ==========================================================================
  // Next state
  // ==========================================================================
  cmp_cfg_t [NUM_CMP-1:0] cfg;
  assign cfg[0] = first_comparator_cfg_i; // R1
  assign cfg[1] = second_comparator_cfg_i;

  always_comb begin
    state_nxt = state_r;
    for (int i = 0; i < NUM_CMP; i++) begin
      state_nxt.flags[i].result   = cmp_step(cfg[i], actual_i, refs_i,
                                             state_r.flags[i].result); // R1 R20
      state_nxt.flags[i].result_n = ~state_nxt.flags[i].result; // R21
      state_nxt.clamped[i]        = out_of_range(cfg[i].on_above)
                                 || out_of_range(cfg[i].off_below);
    end
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < NUM_CMP; i++) begin
        state_r.flags[i].result   <= 1'b0; // R22
        state_r.flags[i].result_n <= 1'b1; // R21
      end
      state_r.clamped <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign first_comparator_o  = state_r.flags[0];
  assign second_comparator_o = state_r.flags[1];
  assign cfg_clamped_o       = state_r.clamped;

endmodule // dual_hysteresis_comparator

`default_nettype wire

// ---- tb/cmp_monitor.sv ----
// Checker for the dual hysteresis comparator outputs
`timescale 1ns/1ps
`default_nettype none
module cmp_monitor
  import cmp_pkg::*;
(
  input wire logic           core_clk_i,
  input wire logic           rst_i,
  input wire actual_values_t actual_i,
  input wire references_t    refs_i,
  input wire cmp_cfg_t       first_comparator_cfg_i,
  input wire cmp_cfg_t       second_comparator_cfg_i,
  input wire cmp_flags_t     first_comparator_o,
  input wire cmp_flags_t     second_comparator_o,
  input wire logic [1:0]     cfg_clamped_o
);
  // ==========================================
  // DC-link view of the first comparator
  logic signed [23:0] ad;
  logic signed [39:0] dv, ton, toff;
  logic               m9;
  assign ad   = actual_i.dclink_voltage[23] ? -actual_i.dclink_voltage : actual_i.dclink_voltage;
  assign dv   = 40'(ad) * 40'sd10000;
  assign ton  = 40'(first_comparator_cfg_i.on_above) * 40'sd1000;
  assign toff = 40'(first_comparator_cfg_i.off_below) * 40'sd1000;
  // Clamped thresholds are left out since ton and toff use the unclamped values
  assign m9 = first_comparator_cfg_i.mode == MODE_DCLINK
    && first_comparator_cfg_i.on_above inside {[PCT_MIN:PCT_MAX]}
    && first_comparator_cfg_i.off_below inside {[PCT_MIN:PCT_MAX]};
  sequence dc_above_s; m9 && dv > ton; endsequence
  sequence dc_below_s; m9 && dv <= ton && dv < toff; endsequence
  sequence dc_between_s; m9 && dv <= ton && dv >= toff; endsequence
  // ==========================================
  // Assertions
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  inv_first_a: assert property (
    first_comparator_o.result_n == !first_comparator_o.result)
    else $error("first flag pair not complementary");
  inv_second_a: assert property (
    second_comparator_o.result_n == !second_comparator_o.result)
    else $error("second flag pair not complementary");
  off_first_a: assert property (
    first_comparator_cfg_i.mode == MODE_OFF |=> !first_comparator_o.result)
    else $error("first comparator active while off");
  off_second_a: assert property (
    second_comparator_cfg_i.mode == MODE_OFF |=> !second_comparator_o.result)
    else $error("second comparator active while off");
  reset_idle_a: assert property (
    $fell(rst_i) |-> !first_comparator_o.result && !second_comparator_o.result
      && cfg_clamped_o == 2'h0)
    else $error("outputs not idle after reset");
  dc_on_a: assert property (dc_above_s |=> first_comparator_o.result)
    else $error("dc-link compare did not switch on");
  dc_off_a: assert property (dc_below_s |=> !first_comparator_o.result)
    else $error("dc-link compare did not switch off");
  dc_hold_a: assert property (dc_between_s |=> $stable(first_comparator_o.result))
    else $error("result moved between thresholds");
  clamp_on_a: assert property (
    first_comparator_cfg_i.on_above > PCT_MAX |=> cfg_clamped_o[0])
    else $error("oversize threshold not flagged");
  clamp_off_a: assert property (
    second_comparator_cfg_i.off_below > PCT_MAX |=> cfg_clamped_o[1])
    else $error("oversize off threshold not flagged");
  signed_gap_a: assert property (
    first_comparator_cfg_i.mode == 8'h6D |=> !first_comparator_o.result)
    else $error("unlisted signed mode active");
endmodule // cmp_monitor
bind dual_hysteresis_comparator cmp_monitor u_mon (.core_clk_i(core_clk_i), .rst_i(rst_i),
  .actual_i(actual_i), .refs_i(refs_i), .first_comparator_cfg_i(first_comparator_cfg_i),
  .second_comparator_cfg_i(second_comparator_cfg_i), .first_comparator_o(first_comparator_o),
  .second_comparator_o(second_comparator_o), .cfg_clamped_o(cfg_clamped_o));
`default_nettype wire

// ---- tb/test_dual_hysteresis_comparator.sv ----
// Self-checking bench for the dual hysteresis comparator
`timescale 1ns/1ps
`default_nettype none
module test_dual_hysteresis_comparator import cmp_pkg::*;;
  logic           core_clk_i = 1'b0;
  logic           rst_i = 1'b1;
  actual_values_t act = '0;
  references_t    refs = '0;
  cmp_cfg_t       cfg1 = '0;
  cmp_cfg_t       cfg2 = '0;
  cmp_flags_t     out1, out2;
  logic [1:0]     clamped, ec;
  logic           e1 = 1'b0, e2 = 1'b0;
  int             num_errors = 0, samples_checked = 0, cyc = 0, amp = 500;
  // ==========================================
  // Quantity field and reference slot per base mode, -1 for none
  int src[16] = '{-1, 0, 1, 2, 3, 4, 5, 6, -1, 7, 8, 9, 10, 11, 12, 13};
  int rsel[16] = '{0, 0, 0, 1, 2, 1, 4, 1, 0, 5, 0, 0, 1, 3, 3, 6};
  always #5 core_clk_i = ~core_clk_i;
  dual_hysteresis_comparator DUT (.core_clk_i(core_clk_i), .rst_i(rst_i), .actual_i(act),
    .refs_i(refs), .first_comparator_cfg_i(cfg1), .second_comparator_cfg_i(cfg2),
    .first_comparator_o(out1), .second_comparator_o(out2), .cfg_clamped_o(clamped));
  function automatic logic signed [15:0] clip(logic signed [15:0] p);
    return p > PCT_MAX ? PCT_MAX : (p < PCT_MIN ? PCT_MIN : p);
  endfunction
  function automatic logic model(cmp_cfg_t c, logic prev);
    logic               sg;
    int                 b;
    logic signed [47:0] v, rf;
    sg = c.mode inside {[8'h64:8'h6B], 8'h6F, 8'h70};
    b = sg ? int'(c.mode) - 100 : int'(c.mode);
    if (b > 15 || src[b] < 0) return 1'b0;
    v = 48'($signed(act[(13 - src[b]) * VAL_W +: VAL_W]));
    rf = rsel[b] < 4 ? 48'($signed(refs[(3 - rsel[b]) * VAL_W +: VAL_W])) : rsel[b] == 4 ?
      48'(TEMP_REF) : rsel[b] == 5 ? 48'(DCLINK_REF) : 48'(ANALOG_FULL_REF);
    if (!sg && v < 0) v = -v;
    if (v * 10000 > rf * clip(c.on_above)) return 1'b1;
    if (v * 10000 < rf * clip(c.off_below)) return 1'b0;
    return prev;
  endfunction
  function automatic logic oor(cmp_cfg_t c);
    return c.on_above != clip(c.on_above) || c.off_below != clip(c.off_below);
  endfunction
  function automatic cmp_cfg_t rcfg();
    cmp_cfg_t c;
    c.mode = 8'($urandom_range(0, 15));
    if ($urandom_range(0, 2) == 0) c.mode = c.mode + SIGNED_OFS;
    c.on_above = 16'(int'($urandom_range(0, 60000)) - 30000);
    c.off_below = c.on_above - 16'(int'($urandom_range(0, 9000)) - 1000);
    if ($urandom_range(0, 15) == 0) c.on_above = 16'h7FFF;
    return c;
  endfunction
  // ==========================================
  // Checking
  task test_done();
    $display("errors %0d, checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task chk_flags(cmp_flags_t got, logic e);
    samples_checked++;
    if (got !== {e, !e}) begin
      num_errors++;
      $display("unexpected at %0t: flags %b, want result %b", $time, got, e);
    end
  endtask
  task chk_bits(logic [1:0] got, logic [1:0] e);
    samples_checked++;
    if (got !== e) begin
      num_errors++;
      $display("unexpected at %0t: clamp bits %b, want %b", $time, got, e);
    end
  endtask
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    e1 <= rst_i ? 1'b0 : model(cfg1, e1);
    e2 <= rst_i ? 1'b0 : model(cfg2, e2);
    ec <= rst_i ? 2'h0 : {oor(cfg2), oor(cfg1)};
    if (cyc == 5000) begin
      num_errors++;
      test_done();
    end
  end
  // Outputs settle half a period after the launching edge
  always @(negedge core_clk_i) if (cyc > 1) begin
    chk_flags(out1, e1);
    chk_flags(out2, e2);
    chk_bits(clamped, ec);
  end
  // ==========================================
  // Stimulus
  initial begin
    void'($urandom(32'h81A3A7E4));
    repeat (12) @(posedge core_clk_i);
    rst_i <= 1'b0;
    cfg1 <= '{MODE_OUT_F, 16'sh1F40, 16'sh1388};
    // Undecoded mode with both limits out of range: off, and flagged
    cfg2 <= '{8'h50, 16'sh8000, 16'sh7FFF};
    refs.max_frequency <= 24'sh001388;
    act.output_freq <= 24'sh001004;
    @(posedge core_clk_i) act.output_freq <= 24'sh000BB8;
    @(posedge core_clk_i) act.output_freq <= 24'sh000960;
    @(posedge core_clk_i) act.output_freq <= -24'sh001004;
    @(posedge core_clk_i) cfg1.mode <= 8'h6B;
    for (int n = 0; n < 3000; n++) begin
      @(posedge core_clk_i);
      // Short reset in mid-run, while results are live
      rst_i <= (n >= 1500) && (n < 1503);
      if ($urandom_range(0, 31) == 0) begin
        cfg1 <= rcfg();
        cfg2 <= rcfg();
        amp = $urandom_range(50, 12000);
        for (int i = 0; i < 4; i++) refs[i * VAL_W +: VAL_W] <= VAL_W'($urandom_range(100, 8000));
      end
      for (int i = 0; i < 14; i++)
        act[i * VAL_W +: VAL_W] <= VAL_W'(int'($urandom_range(0, 2 * amp)) - amp);
    end
    test_done();
  end
endmodule // test_dual_hysteresis_comparator
`default_nettype wire
